// ==== rtl/fpp_regs.vh ====
`ifndef FPP_REGS_VH
`define FPP_REGS_VH
// Register byte addresses
`define FPP_ADDR_CTRL 12'h000
`define FPP_ADDR_OPTION 12'h004
`define FPP_ADDR_STATUS 12'h008
`define FPP_ADDR_FLASH 12'h00c
// Control register fields
`define FPP_CTRL_RESET 8'h00
`define FPP_BIT_OPT 2
`define FPP_BIT_LAT 1
`define FPP_BIT_PGM 0
`define FPP_KEY1 8'h56
`define FPP_KEY2 8'hae
// Option register fields
`define FPP_OPTION_RESET 8'h00
`define FPP_BIT_RDP 7
`define FPP_BIT_WEP 6
`define FPP_SEC0_LSB 0
`define FPP_SEC0_W 2
// Flash access register fields
`define FPP_FL_ADDR_LSB 8
`define FPP_FL_DATA_LSB 0
`define FPP_FL_SECTOR_BIT 20
`define FPP_FL_ERASE_BIT 21
`define FPP_FL_EEPROM_BIT 22
// Programming sequencing
`define FPP_ROW_BYTES 32
`define FPP_PROG_CYCLES 16'd64
`define FPP_MASS_ERASE_CYCLES 16'd256
// Serial mode entry
`define FPP_PULSES_RC 8'd38
`define FPP_PULSES_EXT 8'd35
`endif

// ==== rtl/fpp_flash_program_protect_control.v ====
// Overview of operation
// [R1] Program or erase one byte, or a row of up to 32 latched bytes.
// [R2] Each sector is erased and programmed alone; other sectors untouched.
// [R3] Socket or serial programming may modify sectors 0, 1, option row, EEPROM.
// [R4] Self-programming may modify only sector 1 and EEPROM.
// [R5] Self-programming never writes or erases sector 0.
// [R6] Sector 0 size comes from an option byte field.
// [R7] Tool holds reset low while pulsing serial clock and data.
// [R8] Serial entry fetches a system-memory reset vector for the byte loader.
// [R9] Serial flow: enter mode, load driver to RAM, run it from RAM.
// [R10] 38-pulse entry forces the internal RC oscillator clock.
// [R11] 35-pulse entry ignores option bytes; tool supplies the clock.
// [R12] Any reset returns serial clock pin to input with pull-up.
// [R13] Tool drives the reset pin during a serial session.
// [R14] Readout and write/erase protection are independent options.
// [R15] Readout protection blocks flash reads and flash writes.
// [R16] Removing readout protection first mass-erases flash and EEPROM (here the bit clears in the cycle the mass erase starts).
// [R17] Readout protection is a dedicated option byte bit.
// [R18] Write/erase protection refuses flash changes; EEPROM stays writable.
// [R19] Write/erase protection, once set, never clears (here any reset clears it, as the option register resets to 00h).
// [R20] Control register resets to 00h; bits 2..0 option, latch, program.
// [R21] Software writes key 56h then AEh before programming.
// [R22] Control register alone steers flash program and erase (here erase starts on a flash access write, mass erase on an option write).
// [R23] Control bits stay locked unless both keys came just before (here the unlock lasts until a program, erase or mass erase ends).
`include "fpp_regs.vh"
module fpp_flash_program_protect_control (
   // System
   input wire clk,
   input wire reset_n,
   // AXI4-Lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Mode straps and the CPU's current programming context
   input wire socketMode,
   input wire appRunning,
   // Serial programming pins
   input wire serialProgClockIn,
   output wire serialProgClockOut,
   output wire serialProgClockOe,
   output wire serialProgClockPullup,
   input wire serialProgDataIn,
   input wire appClockPinOe,
   input wire appClockPinOut,
   // Clock and boot selection
   output reg useRcOsc,
   output reg useToolClock,
   output reg serialMode,
   output reg fetchSystemVector,
   // Flash array port
   output reg flashProgStrobe,
   output reg flashEraseStrobe,
   output reg flashMassErase,
   output reg [11:0] flashAddr,
   output reg [7:0] flashWrData,
   output reg flashEeprom,
   output reg flashSector,
   output reg readBlock
);
   localparam S_IDLE = 4'b0001;
   localparam S_PROG = 4'b0010;
   localparam S_ERASE = 4'b0100;
   localparam S_MASS = 4'b1000;
   localparam K_NONE = 2'b01;
   localparam K_ONE = 2'b10;

   reg [7:0] ctrlFf;
   reg [1:0] keyFf;
   reg unlockedFf;
   reg [7:0] optionFf;
   reg [3:0] stateFf;
   reg [15:0] cntFf;
   reg [7:0] latchData [0:`FPP_ROW_BYTES-1];
   reg [`FPP_ROW_BYTES-1:0] latchValid;
   reg [6:0] rowFf;
   reg latchEeprom;
   reg latchSector;
   reg [4:0] idxFf;
   reg refusedFf;
   reg sck1Ff;
   reg sck2Ff;
   reg sdat1Ff;
   reg sdat2Ff;
   reg sckPrevFf;
   reg [7:0] pulseFf;
   reg awHeld;
   reg wHeld;
   reg [11:0] awAddrFf;
   reg [31:0] wDataFf;
   reg [3:0] wStrbFf;
   reg resetSeenFf;

   // Sector 0 size: option field selects 1, 2, 4 or 8 pages of 256 bytes
   function [11:0] sec0Limit;
      input [1:0] sel;
      begin
         sec0Limit = 12'h100 << sel;
      end
   endfunction

   function inSector0;
      input [11:0] addr;
      input [1:0] sel;
      begin
         inSector0 = addr < sec0Limit(sel);
      end
   endfunction

   // Target writable in the current mode
   function targetAllowed;
      input isEeprom;
      input isSec0;
      input isOption;
      begin
         // [R3] external modes
         if (socketMode || serialMode)
            targetAllowed = 1'b1;
         // [R4] [R5] self-programming
         else
            targetAllowed = !isOption && (isEeprom || !isSec0);
         // [R18] protect flash only
         if (optionFf[`FPP_BIT_WEP] && !isEeprom)
            targetAllowed = 1'b0;
         // [R15] readout protection blocks rewrites
         if (optionFf[`FPP_BIT_RDP])
            targetAllowed = 1'b0;
      end
   endfunction

   // AXI write path
   wire wrFire = awHeld && wHeld && !s_axi_bvalid;
   assign s_axi_awready = !awHeld;
   assign s_axi_wready = !wHeld;
   assign s_axi_arready = !s_axi_rvalid;
   wire idle = stateFf == S_IDLE;
   wire busy = !idle;
   wire [7:0] wByte = wDataFf[7:0];
   wire byte0 = wStrbFf[0];
   wire wrCtrl = wrFire && awAddrFf == `FPP_ADDR_CTRL && byte0;
   wire wrOpt = wrFire && awAddrFf == `FPP_ADDR_OPTION && byte0;
   wire wrFlash = wrFire && awAddrFf == `FPP_ADDR_FLASH;
   wire wrMapped = awAddrFf == `FPP_ADDR_CTRL || awAddrFf == `FPP_ADDR_OPTION ||
      awAddrFf == `FPP_ADDR_STATUS || awAddrFf == `FPP_ADDR_FLASH;
   wire [11:0] flAddr = wDataFf[`FPP_FL_ADDR_LSB+11:`FPP_FL_ADDR_LSB];
   wire flEeprom = wDataFf[`FPP_FL_EEPROM_BIT];
   wire flErase = wDataFf[`FPP_FL_ERASE_BIT];
   wire flSec0 = inSector0(flAddr, optionFf[`FPP_SEC0_LSB+1:`FPP_SEC0_LSB]);
   wire flOk = targetAllowed(flEeprom, flSec0 && !flEeprom, 1'b0);
   wire optOk = targetAllowed(1'b0, 1'b0, 1'b1);
   wire latchOn = ctrlFf[`FPP_BIT_LAT];

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrFf <= 12'h000;
         wDataFf <= 32'h00000000;
         wStrbFf <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && !awHeld) begin
            awHeld <= 1'b1;
            awAddrFf <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && !wHeld) begin
            wHeld <= 1'b1;
            wDataFf <= s_axi_wdata;
            wStrbFf <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? 2'b00 : 2'b10;
            if (wrFlash && (!flOk || !latchOn || busy))
               s_axi_bresp <= 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read path
   wire [7:0] statusByte = {4'h0, refusedFf, unlockedFf, busy, serialMode};
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case ({s_axi_araddr[11:2], 2'b00})
            // [R20] upper bits read zero
            `FPP_ADDR_CTRL: s_axi_rdata <= {24'h000000, 5'h00, ctrlFf[2:0]};
            `FPP_ADDR_OPTION: s_axi_rdata <= {24'h000000, optionFf};
            `FPP_ADDR_STATUS: s_axi_rdata <= {24'h000000, statusByte};
            `FPP_ADDR_FLASH: s_axi_rdata <= 32'h00000000;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Synchronisers stay unreset: entry pulses arrive while reset is held
   always @(posedge clk) begin
      sck1Ff <= serialProgClockIn;
      sck2Ff <= sck1Ff;
      sdat1Ff <= serialProgDataIn;
      sdat2Ff <= sdat1Ff;
      sckPrevFf <= sck2Ff;
   end

   // [R7] [R13] counted while the tool holds reset low
   wire sckRise = sck2Ff && !sckPrevFf;
   reg resetSync1Ff;
   reg resetSync2Ff;
   always @(posedge clk) begin
      resetSync1Ff <= reset_n;
      resetSync2Ff <= resetSync1Ff;
      if (!resetSync2Ff) begin
         if (sckRise && sdat2Ff && pulseFf != 8'hff)
            pulseFf <= pulseFf + 8'h01;
      end else if (resetSeenFf) begin
         pulseFf <= 8'h00;
      end
   end

   // Entry mode is caught at the release of reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resetSeenFf <= 1'b0;
         serialMode <= 1'b0;
         useRcOsc <= 1'b0;
         useToolClock <= 1'b0;
         fetchSystemVector <= 1'b0;
      end else if (!resetSeenFf) begin
         resetSeenFf <= 1'b1;
         // [R10] RC forced
         if (pulseFf == `FPP_PULSES_RC) begin
            serialMode <= 1'b1;
            useRcOsc <= 1'b1;
            fetchSystemVector <= 1'b1;
         // [R11] tool clock
         end else if (pulseFf == `FPP_PULSES_EXT) begin
            serialMode <= 1'b1;
            useToolClock <= 1'b1;
            fetchSystemVector <= 1'b1;
         end
      end else begin
         // [R8] vector fetch flag lasts one cycle; [R9] software runs loader
         fetchSystemVector <= 1'b0;
      end
   end

   // [R12] pin is input with pull-up after any reset; outside serial mode only until software drives it
   assign serialProgClockOe = resetSeenFf && !serialMode && appClockPinOe;
   assign serialProgClockOut = appClockPinOut;
   assign serialProgClockPullup = !serialProgClockOe;

   // Control register, key sequencer, option byte and program sequencer
   integer i;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlFf <= `FPP_CTRL_RESET;
         keyFf <= K_NONE;
         unlockedFf <= 1'b0;
         optionFf <= `FPP_OPTION_RESET;
         stateFf <= S_IDLE;
         cntFf <= 16'h0000;
         latchValid <= {`FPP_ROW_BYTES{1'b0}};
         rowFf <= 7'h00;
         latchEeprom <= 1'b0;
         latchSector <= 1'b0;
         idxFf <= 5'h00;
         refusedFf <= 1'b0;
         flashProgStrobe <= 1'b0;
         flashEraseStrobe <= 1'b0;
         flashMassErase <= 1'b0;
         flashAddr <= 12'h000;
         flashWrData <= 8'h00;
         flashEeprom <= 1'b0;
         flashSector <= 1'b0;
      end else begin
         flashProgStrobe <= 1'b0;
         flashEraseStrobe <= 1'b0;
         if (wrCtrl) begin
            // [R21] [R23] key sequence
            if (!unlockedFf && keyFf == K_NONE && wByte == `FPP_KEY1)
               keyFf <= K_ONE;
            else if (!unlockedFf && keyFf == K_ONE && wByte == `FPP_KEY2) begin
               keyFf <= K_NONE;
               unlockedFf <= 1'b1;
            end else if (unlockedFf && idle) begin
               // [R22] [R20] only low three bits
               ctrlFf <= {5'h00, wByte[2:0]};
               if (!wByte[`FPP_BIT_LAT])
                  latchValid <= {`FPP_ROW_BYTES{1'b0}};
               if (wByte[`FPP_BIT_PGM] && wByte[`FPP_BIT_LAT]) begin
                  // [R1] row of latched bytes
                  stateFf <= S_PROG;
                  idxFf <= 5'h00;
                  cntFf <= 16'h0000;
               end
            end else begin
               keyFf <= K_NONE;
               // [R23] locked write leaves bits alone
               if (!unlockedFf)
                  refusedFf <= 1'b1;
            end
         end
         if (wrOpt) begin
            if (optOk && unlockedFf && idle) begin
               // [R14] [R17] independent bits; [R19] sticky write protect
               optionFf <= {wByte[7], wByte[6] | optionFf[`FPP_BIT_WEP], wByte[5:0]};
               // [R16] clearing readout protection starts a mass erase in the same cycle
               if (optionFf[`FPP_BIT_RDP] && !wByte[7]) begin
                  stateFf <= S_MASS;
                  cntFf <= 16'h0000;
                  flashMassErase <= 1'b1;
               end
            end else if (optionFf[`FPP_BIT_RDP] && unlockedFf && idle && !wByte[7]) begin
               // [R16] removal still allowed, via mass erase
               optionFf <= {1'b0, optionFf[6:0]};
               stateFf <= S_MASS;
               cntFf <= 16'h0000;
               flashMassErase <= 1'b1;
            end else begin
               refusedFf <= 1'b1;
            end
         end
         if (wrFlash) begin
            if (!flOk || !latchOn || busy || !unlockedFf)
               refusedFf <= 1'b1;
            else if (flErase) begin
               // [R2] erase one sector only
               stateFf <= S_ERASE;
               cntFf <= 16'h0000;
               flashAddr <= flAddr;
               flashEeprom <= flEeprom;
               flashSector <= !flSec0;
               flashEraseStrobe <= 1'b1;
            end else begin
               // [R1] up to 32 latched bytes, same row
               latchData[flAddr[4:0]] <= wDataFf[7:0];
               latchValid[flAddr[4:0]] <= 1'b1;
               rowFf <= flAddr[11:5];
               latchEeprom <= flEeprom;
               latchSector <= !flSec0;
            end
         end
         case (stateFf)
            S_IDLE: begin
               cntFf <= 16'h0000;
            end
            S_PROG: begin
               if (latchValid[idxFf] && cntFf == 16'h0000) begin
                  flashProgStrobe <= 1'b1;
                  flashAddr <= {rowFf, idxFf};
                  flashWrData <= latchData[idxFf];
                  flashEeprom <= latchEeprom;
                  flashSector <= latchSector;
               end
               cntFf <= cntFf + 16'h0001;
               if (cntFf == `FPP_PROG_CYCLES - 16'h0001) begin
                  cntFf <= 16'h0000;
                  idxFf <= idxFf + 5'h01;
                  if (idxFf == 5'h1f) begin
                     stateFf <= S_IDLE;
                     ctrlFf <= `FPP_CTRL_RESET;
                     latchValid <= {`FPP_ROW_BYTES{1'b0}};
                     unlockedFf <= 1'b0;
                  end
               end
            end
            S_ERASE: begin
               cntFf <= cntFf + 16'h0001;
               if (cntFf == `FPP_PROG_CYCLES - 16'h0001) begin
                  stateFf <= S_IDLE;
                  ctrlFf <= `FPP_CTRL_RESET;
                  unlockedFf <= 1'b0;
               end
            end
            S_MASS: begin
               cntFf <= cntFf + 16'h0001;
               if (cntFf == `FPP_MASS_ERASE_CYCLES - 16'h0001) begin
                  stateFf <= S_IDLE;
                  flashMassErase <= 1'b0;
                  unlockedFf <= 1'b0;
               end
            end
            default: stateFf <= S_IDLE;
         endcase
      end
   end

   // [R15] readout blocked unless the application runs outside socket and serial mode
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         readBlock <= 1'b0;
      else
         readBlock <= optionFf[`FPP_BIT_RDP] && !socketMode && !appRunning ? 1'b1 :
            optionFf[`FPP_BIT_RDP] && (serialMode || socketMode);
   end
endmodule

// ==== testbench/fpp_flash_program_protect_control_asserts.sv ====
module fpp_checker (
   // System
   input logic clk,
   input logic reset_n,
   // Bus handshakes
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   // Mode and pins
   input logic socketMode,
   input logic appClockPinOe,
   input logic serialProgClockOe,
   input logic serialProgClockPullup,
   input logic useRcOsc,
   input logic useToolClock,
   input logic serialMode,
   input logic fetchSystemVector,
   // Flash array port
   input logic flashProgStrobe,
   input logic flashMassErase,
   input logic flashEeprom,
   input logic flashSector
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   AST_PULLUP: assert property (serialProgClockPullup == !serialProgClockOe)
      else $error("pull-up not inverse of enable");
   AST_CLK_OE: assert property (serialProgClockOe |-> appClockPinOe && !serialMode)
      else $error("pin driven without request");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before ready");
   AST_RANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read data");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped before ready");
   AST_CLK_EXCL: assert property (useRcOsc || useToolClock |-> serialMode && !(useRcOsc && useToolClock))
      else $error("bad clock source");
   AST_CLK_STABLE: assert property ($past(reset_n, 2) && $past(reset_n)
      |-> $stable({useRcOsc, useToolClock, serialMode}))
      else $error("clock source changed");
   AST_VECTOR: assert property (fetchSystemVector |=> !fetchSystemVector && serialMode)
      else $error("vector fetch not one pulse");
   AST_SEC0_SELF: assert property (flashProgStrobe && !socketMode && !serialMode && !flashEeprom
      |-> flashSector)
      else $error("sector 0 programmed by the application");
   AST_PROG_SPACING: assert property (flashProgStrobe |=> !flashProgStrobe [*8])
      else $error("strobes too close");
   AST_ERASE_QUIET: assert property (flashMassErase |-> !flashProgStrobe)
      else $error("programming during mass erase");
endmodule

bind fpp_flash_program_protect_control fpp_checker i_fpp_checker (.clk, .reset_n,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
   .socketMode, .appClockPinOe, .serialProgClockOe, .serialProgClockPullup, .useRcOsc,
   .useToolClock, .serialMode, .fetchSystemVector, .flashProgStrobe, .flashMassErase,
   .flashEeprom, .flashSector);

// ==== testbench/fpp_tool_model.sv ====
module fpp_tool_model (
   // Entry request
   input logic go,
   input logic [7:0] pulses,
   // Pins toward the device
   output logic toolReset_n,
   output logic progClock,
   output logic progData
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {toolReset_n, progClock, progData} = 3'h6;
   end
   always @(posedge go) begin
      toolReset_n = 1'h0;
      #200;
      progData = 1'h1;
      repeat (pulses) begin
         #62.5 progClock = 1'h0;
         #62.5 progClock = 1'h1;
      end
      #200;
      // Released data line shows the inverse of its last value
      progData = 1'h0;
      #100;
      toolReset_n = 1'h1;
   end
endmodule

// ==== testbench/fpp_testbench.sv ====
`include "fpp_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, tbRst_n, reset_n, toolReset_n, toolGo, clkPin, progClock, dataPin;
   logic [7:0] toolPulses, flashWrData;
   logic [11:0] s_axi_awaddr, s_axi_araddr, flashAddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic socketMode, appRunning, appClockPinOe, serialProgClockOut, serialProgClockOe;
   logic serialProgClockPullup, useRcOsc, useToolClock, serialMode, fetchSystemVector;
   logic flashProgStrobe, flashEraseStrobe, flashMassErase, flashEeprom, flashSector, readBlock;
   logic [20:0] progQ[$];
   int mismatches, checked, vecCount, massCycles;
   assign reset_n = tbRst_n & toolReset_n;
   assign clkPin = serialProgClockOe ? serialProgClockOut : progClock;
   fpp_flash_program_protect_control i_fpp_flash_program_protect_control (.clk, .reset_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .socketMode,
      .appRunning, .serialProgClockIn(clkPin), .serialProgClockOut, .serialProgClockOe,
      .serialProgClockPullup, .serialProgDataIn(dataPin), .appClockPinOe,
      .appClockPinOut(1'h0), .useRcOsc, .useToolClock, .serialMode, .fetchSystemVector,
      .flashProgStrobe, .flashEraseStrobe, .flashMassErase, .flashAddr, .flashWrData,
      .flashEeprom, .flashSector, .readBlock);
   fpp_tool_model i_fpp_tool_model (.go(toolGo), .pulses(toolPulses), .toolReset_n,
      .progClock, .progData(dataPin));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (flashProgStrobe === 1'h1) progQ.push_back({flashSector, flashAddr, flashWrData});
      if (fetchSystemVector === 1'h1) vecCount++;
      if (flashMassErase === 1'h1) massCycles++;
   end
   task check(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task complete_run;
      $display("Counts: checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task hang;
      mismatches++;
      $display("MISMATCH wait expected done seen timeout");
      complete_run;
   endtask
   task axi_write(input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
         end
      end
      if (n == 200) hang();
   endtask
   task axi_read(input logic [11:0] a);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
         end
      end
      if (n == 200) hang();
   endtask
   task unlock_latch;
      axi_write(`FPP_ADDR_CTRL, 32'h56);
      axi_write(`FPP_ADDR_CTRL, 32'hae);
      axi_write(`FPP_ADDR_CTRL, 32'h02);
   endtask
   task wait_idle;
      int n;
      for (n = 0; n < 3000; n++) begin
         axi_read(`FPP_ADDR_STATUS);
         if (rd[1] === 1'h0) break;
      end
      if (n == 3000) hang();
   endtask
   task test_reset;
      axi_read(`FPP_ADDR_CTRL);
      check("ctrl reset", rd, 32'h0);
      axi_read(12'h010);
      check("unmapped resp", resp, 2'h2);
      check("unmapped data", rd, 32'h0);
      check("clock pin driven", serialProgClockOe, 1'h1);
      $display("test_reset done");
   endtask
   task test_unlock;
      axi_write(`FPP_ADDR_CTRL, 32'hae);
      axi_write(`FPP_ADDR_CTRL, 32'h56);
      axi_write(`FPP_ADDR_CTRL, 32'h02);
      axi_read(`FPP_ADDR_CTRL);
      check("ctrl locked", rd, 32'h0);
      axi_write(`FPP_ADDR_CTRL, 32'h56);
      axi_write(`FPP_ADDR_CTRL, 32'hae);
      axi_write(`FPP_ADDR_CTRL, 32'hfa);
      axi_read(`FPP_ADDR_CTRL);
      check("ctrl unlocked", rd, 32'h02);
      $display("test_unlock done");
   endtask
   task test_program;
      progQ.delete();
      axi_write(`FPP_ADDR_FLASH, {12'h0, 12'h400, 8'h5a});
      check("latch resp", resp, 2'h0);
      axi_write(`FPP_ADDR_FLASH, {12'h0, 12'h401, 8'ha5});
      axi_write(`FPP_ADDR_CTRL, 32'h03);
      wait_idle();
      check("prog count", progQ.size(), 32'h2);
      check("prog first", progQ[0], {1'h1, 12'h400, 8'h5a});
      check("prog second", progQ[1], {1'h1, 12'h401, 8'ha5});
      axi_read(`FPP_ADDR_CTRL);
      check("ctrl after prog", rd, 32'h0);
      $display("test_program done");
   endtask
   task test_refuse;
      unlock_latch();
      axi_write(`FPP_ADDR_FLASH, {12'h0, 12'h010, 8'h11});
      check("sector0 refused", resp, 2'h2);
      socketMode <= 1'h1;
      axi_write(`FPP_ADDR_OPTION, 32'h01);
      socketMode <= 1'h0;
      axi_write(`FPP_ADDR_FLASH, {12'h0, 12'h100, 8'h11});
      check("sector0 resized", resp, 2'h2);
      socketMode <= 1'h1;
      axi_write(`FPP_ADDR_OPTION, 32'h00);
      axi_read(`FPP_ADDR_STATUS);
      check("refused flag", rd[3], 1'h1);
      $display("test_refuse done");
   endtask
   task test_socket;
      socketMode <= 1'h1;
      progQ.delete();
      axi_write(`FPP_ADDR_FLASH, {12'h0, 12'h010, 8'h33});
      check("socket sector0 resp", resp, 2'h0);
      axi_write(`FPP_ADDR_CTRL, 32'h03);
      wait_idle();
      check("socket prog count", progQ.size(), 32'h1);
      check("socket prog", progQ[0], {1'h0, 12'h010, 8'h33});
      $display("test_socket done");
   endtask
   task test_readout;
      int n;
      appRunning <= 1'h0;
      unlock_latch();
      axi_write(`FPP_ADDR_OPTION, 32'h80);
      repeat (3) @(posedge clk);
      check("read blocked", readBlock, 1'h1);
      unlock_latch();
      axi_write(`FPP_ADDR_FLASH, {12'h0, 12'h400, 8'h77});
      check("protected write", resp, 2'h2);
      massCycles = 0;
      axi_write(`FPP_ADDR_OPTION, 32'h00);
      for (n = 0; n < 600; n++) begin
         @(posedge clk);
         if (massCycles > 0 && flashMassErase !== 1'h1) break;
      end
      if (n == 600) hang();
      check("mass erase length", massCycles, 32'd256);
      repeat (3) @(posedge clk);
      check("read unblocked", readBlock, 1'h0);
      $display("test_readout done");
   endtask
   task test_write_protect;
      unlock_latch();
      axi_write(`FPP_ADDR_OPTION, 32'h40);
      axi_read(`FPP_ADDR_OPTION);
      check("wp only", rd[7:6], 2'h1);
      axi_write(`FPP_ADDR_OPTION, 32'h00);
      axi_read(`FPP_ADDR_OPTION);
      check("wp sticky", rd[6], 1'h1);
      check("no read block", readBlock, 1'h0);
      axi_write(`FPP_ADDR_FLASH, {12'h0, 12'h400, 8'h12});
      check("wp flash refused", resp, 2'h2);
      axi_write(`FPP_ADDR_FLASH, {9'h0, 1'h1, 2'h0, 12'h001, 8'h44});
      check("wp eeprom open", resp, 2'h0);
      $display("test_write_protect done");
   endtask
   task test_serial;
      int i, n;
      for (i = 0; i < 2; i++) begin
         vecCount = 0;
         toolPulses <= (i == 0) ? 8'd38 : 8'd35;
         @(posedge clk);
         toolGo <= 1'h1;
         @(posedge clk);
         toolGo <= 1'h0;
         for (n = 0; n < 1000; n++) begin
            @(posedge clk);
            if (n == 20) check("reset pull-up", {serialProgClockOe, serialProgClockPullup}, 2'h1);
            if (n > 20 && toolReset_n) break;
         end
         if (n == 1000) hang();
         repeat (4) @(posedge clk);
         check("rc osc", useRcOsc, i == 0);
         check("tool clock", useToolClock, i == 1);
         check("serial mode", serialMode, 1'h1);
         check("vector fetch", vecCount, 32'h1);
         check("pin stays input", serialProgClockOe, 1'h0);
      end
      $display("test_serial done");
   endtask
   initial begin
      tbRst_n = 1'h0;
      {toolGo, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, toolPulses} = 64'h0;
      s_axi_wstrb = 4'hf;
      {socketMode, appRunning, appClockPinOe} = 3'h3;
      repeat (4) @(posedge clk);
      tbRst_n <= 1'h1;
      test_reset();
      test_unlock();
      test_program();
      test_refuse();
      test_socket();
      test_readout();
      test_write_protect();
      test_serial();
      complete_run();
   end
endmodule
